// *** dv/occ_clock_ctrl_asserts.sv ***
// Purpose: port-level checks of the clock controller
// Assumes: one hclk domain, hready looped back from hreadyout
// Notes: bound into every occ_clock_ctrl
`timescale 1ns/1ps
`include "occ_defs.svh"
module occ_chk (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // status and control
  input wire logic failsafe_monitor_en,
  input wire logic prim_tick,
  input wire logic clock_fail,
  input wire logic pll_enable,
  input wire logic [5:0] pll_n1,
  input wire logic [9:0] pll_m,
  input wire logic [3:0] pll_n2,
  input wire logic low_power_osc_enable,
  input wire logic [5:0] rc_trim,
  input wire logic [2:0] active_source,
  input wire logic fosc_tick,
  input wire logic cy_tick,
  input wire logic cpu_tick
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic wr_w = ce && hsel && hready && htrans[1] && hwrite;
  logic dp_tun_r;
  logic dp_osc_r;
  // data phase markers of tuning and oscillator writes, whose checked fields are never locked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_tun_r <= 1'b0;
      dp_osc_r <= 1'b0;
    end else if (ce) begin
      dp_tun_r <= wr_w && (haddr[11:0] == `OCC_OFS_TUN);
      dp_osc_r <= wr_w && (haddr[11:0] == `OCC_OFS_OSC);
    end
  end
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  n1_range_a: assert property (pll_n1 >= 6'd2 && pll_n1 <= 6'd33)
    else $error("prescale factor out of range");
  m_range_a: assert property (pll_m >= 10'd2 && pll_m <= 10'd513)
    else $error("feedback factor out of range");
  n2_codes_a: assert property (pll_n2 inside {4'h2, 4'h4, 4'h8})
    else $error("postscale factor not 2, 4 or 8");
  pll_mode_a: assert property (active_source inside {3'h1, 3'h3} |-> pll_enable)
    else $error("pll off in a pll mode");
  trim_follow_a: assert property (dp_tun_r |=> rc_trim == $past(hwdata[5:0]))
    else $error("trim output misses write");
  lposc_follow_a: assert property (dp_osc_r |=> low_power_osc_enable == $past(hwdata[1]))
    else $error("low power enable misses write");
  fail_fall_a: assert property ((ce && clock_fail && failsafe_monitor_en) [*3]
    |=> active_source inside {3'h0, 3'h1}) else $error("no fallback on clock failure");
  cy_fosc_a: assert property (cy_tick |-> fosc_tick)
    else $error("instruction tick without oscillator tick");
  cpu_cy_a: assert property (cpu_tick |-> cy_tick)
    else $error("processor tick without instruction tick");
  prim_path_a: assert property (active_source == 3'h2 && $past(active_source) == 3'h2
    && $past(active_source, 2) == 3'h2 |-> fosc_tick == $past(prim_tick))
    else $error("primary tick not routed");
  cover property (active_source == 3'h3);
  cover property (cpu_tick);
  cover property (dp_tun_r);
endmodule : occ_chk
bind occ_clock_ctrl occ_chk i_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .failsafe_monitor_en(failsafe_monitor_en), .prim_tick(prim_tick),
  .clock_fail(clock_fail), .pll_enable(pll_enable), .pll_n1(pll_n1), .pll_m(pll_m),
  .pll_n2(pll_n2), .low_power_osc_enable(low_power_osc_enable), .rc_trim(rc_trim),
  .active_source(active_source), .fosc_tick(fosc_tick), .cy_tick(cy_tick),
  .cpu_tick(cpu_tick));

// *** dv/occ_clock_ctrl_tb.sv ***
// Purpose: self-checking bench of the clock controller
// Assumes: zero-wait slave, straps start at the unprogrammed code
// Notes: register rows first, then reset, switch, lock, doze and fail cases
`timescale 1ns/1ps
`include "occ_defs.svh"
module occ_clock_ctrl_tb;
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic [15:0] rexp;
  } occ_row_s;
  localparam occ_row_s ROWS [9] = '{
    '{`OCC_OFS_TUN, 16'hFFFF, 16'h003F}, '{`OCC_OFS_TUN, 16'h0020, 16'h0020},
    '{`OCC_OFS_FBD, 16'hFFFF, 16'h01FF}, '{`OCC_OFS_FBD, 16'h0000, 16'h0000},
    '{`OCC_OFS_DIV, 16'hFFFF, 16'hFFDF}, '{`OCC_OFS_DIV, 16'h0000, 16'h0000},
    '{`OCC_OFS_DIV, 16'h0040, 16'h0040}, '{12'h010, 16'hFFFF, 16'h0000},
    '{`OCC_OFS_OSC, 16'h0702, 16'h7702}};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic monitor_cfg_low = 1'b1;
  logic pll_locked = 1'b0;
  logic clock_fail = 1'b0;
  logic irq_event = 1'b0;
  logic [2:0] strap_src = 3'h7;
  logic [1:0] strap_sub = 2'h1;
  logic [7:0] tick_cnt_r = 8'h00;
  logic hreadyout, hresp, pll_enable, pll_from_primary, low_power_osc_enable;
  logic fosc_tick, cy_tick, cpu_tick;
  logic [31:0] hrdata;
  logic [31:0] rd_data;
  logic [5:0] pll_n1;
  logic [5:0] rc_trim;
  logic [9:0] pll_m;
  logic [3:0] pll_n2;
  logic [1:0] primary_mode;
  logic [2:0] active_source;
  int miscompares = 0;
  int cmp_count = 0;
  int cy_n;
  int cpu_n;
  always #25 hclk = ~hclk;
  // source ticks at distinct rates, frc and prim at one rate in distinct phases, so routing slips show
  always @(posedge hclk) tick_cnt_r <= tick_cnt_r + 8'h01;
  occ_clock_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .initial_source_cfg(strap_src), .primary_submode_cfg(strap_sub),
    .monitor_cfg_low(monitor_cfg_low), .failsafe_monitor_en(1'b1),
    .frc_tick(tick_cnt_r[1:0] == 2'h1), .prim_tick(tick_cnt_r[1:0] == 2'h3),
    .sec_tick(tick_cnt_r[4:0] == 5'h05), .slow_internal_rc_tick(tick_cnt_r[5:0] == 6'h09),
    .pll_tick(tick_cnt_r[0]), .pll_locked(pll_locked), .clock_fail(clock_fail),
    .irq_event(irq_event), .pll_enable(pll_enable), .pll_from_primary(pll_from_primary),
    .pll_n1(pll_n1), .pll_m(pll_m), .pll_n2(pll_n2),
    .low_power_osc_enable(low_power_osc_enable), .rc_trim(rc_trim),
    .primary_mode(primary_mode), .active_source(active_source), .fosc_tick(fosc_tick),
    .cy_tick(cy_tick), .cpu_tick(cpu_tick));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0_0000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_data = hrdata;
  endtask : bus
  task automatic wait_sw();
    int n;
    n = 0;
    do begin
      bus(1'b0, `OCC_OFS_OSC, 16'h0000);
      n++;
    end while (rd_data[0] !== 1'b0 && n < 100);
  endtask : wait_sw
  task automatic count_ticks();
    cy_n = 0;
    cpu_n = 0;
    repeat (400) begin
      @(posedge hclk);
      cy_n += int'(cy_tick);
      cpu_n += int'(cpu_tick);
    end
  endtask : count_ticks
  task automatic irq_pulse();
    irq_event <= 1'b1;
    @(posedge hclk);
    irq_event <= 1'b0;
  endtask : irq_pulse
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    miscompares++;
    results();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i].addr, ROWS[i].wdata);
      bus(1'b0, ROWS[i].addr, 16'h0000);
      chk(rd_data, {16'h0000, ROWS[i].rexp});
      case (ROWS[i].addr)
        `OCC_OFS_TUN: chk(rc_trim, ROWS[i].rexp[5:0]);
        `OCC_OFS_FBD: chk(pll_m, ROWS[i].rexp[8:0] + 10'd2);
        `OCC_OFS_OSC: chk(low_power_osc_enable, ROWS[i].rexp[1]);
        `OCC_OFS_DIV: begin
          chk(pll_n1, ROWS[i].rexp[4:0] + 6'd2);
          chk(pll_n2, ROWS[i].rexp[7:6] == 2'h0 ? 4'h2 : ROWS[i].rexp[7] ? 4'h8 : 4'h4);
        end
        default: chk(hresp, 1'b0);
      endcase
    end
    // second reset in mid-run
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    chk({active_source, pll_m, pll_n2, pll_n1}, {3'h7, 10'd50, 4'h4, 6'd2});
    hresetn <= 1'b1;
    bus(1'b0, `OCC_OFS_OSC, 16'h0000);
    chk(rd_data, 32'h0000_7700);
    bus(1'b0, `OCC_OFS_DIV, 16'h0000);
    chk(rd_data, 32'h0000_3040);
    bus(1'b0, `OCC_OFS_FBD, 16'h0000);
    chk(rd_data, 32'h0000_0030);
    bus(1'b0, `OCC_OFS_TUN, 16'h0000);
    chk(rd_data, 32'h0000_0000);
    // rc postscale by four: one instruction tick every 32 cycles
    bus(1'b1, `OCC_OFS_DIV, 16'h0240);
    count_ticks();
    chk(cy_n >= 12 && cy_n <= 13, 1'b1);
    // switch to primary, then primary with pll held off by lock
    bus(1'b1, `OCC_OFS_OSC, 16'h0201);
    wait_sw();
    chk(rd_data, 32'h0000_2200);
    chk({active_source, primary_mode}, {3'h2, 2'h1});
    bus(1'b1, `OCC_OFS_OSC, 16'h0301);
    repeat (50) @(posedge hclk);
    bus(1'b0, `OCC_OFS_OSC, 16'h0000);
    chk(rd_data, 32'h0000_2301);
    chk({pll_enable, pll_from_primary}, 2'h3);
    pll_locked <= 1'b1;
    wait_sw();
    chk(rd_data, 32'h0000_3320);
    // lock blocks feedback writes only while the monitor strap is one
    bus(1'b1, `OCC_OFS_OSC, 16'h0380);
    bus(1'b1, `OCC_OFS_FBD, 16'h0010);
    bus(1'b0, `OCC_OFS_FBD, 16'h0000);
    chk(rd_data, 32'h0000_0030);
    chk(pll_m, 10'd50);
    monitor_cfg_low <= 1'b0;
    bus(1'b1, `OCC_OFS_FBD, 16'h0010);
    bus(1'b0, `OCC_OFS_FBD, 16'h0000);
    chk(rd_data, 32'h0000_0010);
    chk(pll_m, 10'd18);
    // ratio reduction by four, then recovery on interrupt
    bus(1'b1, `OCC_OFS_DIV, 16'hA800);
    count_ticks();
    chk(cpu_n >= cy_n / 4 - 1 && cpu_n <= cy_n / 4 + 1 && cy_n > 40, 1'b1);
    irq_pulse();
    bus(1'b0, `OCC_OFS_DIV, 16'h0000);
    chk(rd_data, 32'h0000_A000);
    count_ticks();
    chk(cpu_n, cy_n);
    bus(1'b1, `OCC_OFS_DIV, 16'h2800);
    irq_pulse();
    bus(1'b0, `OCC_OFS_DIV, 16'h0000);
    chk(rd_data, 32'h0000_2800);
    // clock failure falls back to the rc with pll and sticks until cleared
    clock_fail <= 1'b1;
    repeat (5) @(posedge hclk);
    clock_fail <= 1'b0;
    repeat (3) @(posedge hclk);
    bus(1'b0, `OCC_OFS_OSC, 16'h0000);
    chk({rd_data[14:12], rd_data[3]}, 4'h3);
    bus(1'b1, `OCC_OFS_OSC, 16'h0302);
    bus(1'b0, `OCC_OFS_OSC, 16'h0000);
    chk({rd_data[3], low_power_osc_enable}, 2'h1);
    // power-on from a pll strap with the high-speed submode
    hresetn <= 1'b0;
    strap_src <= 3'h3;
    strap_sub <= 2'h2;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({active_source, primary_mode}, {3'h3, 2'h2});
    chk({pll_enable, pll_from_primary}, 2'h3);
    bus(1'b0, `OCC_OFS_OSC, 16'h0000);
    chk(rd_data, 32'h0000_3320);
    results();
  end
endmodule : occ_clock_ctrl_tb

// *** hdl/occ_clock_ctrl.sv ***
// Purpose: oscillator select, PLL factor and clock ratio control behind AHB-Lite
// Assumes: clock sources arrive as one-cycle ticks on hclk; straps stable from logic
// Notes: zero-wait slave, always OKAY
`timescale 1ns/1ps
`include "occ_defs.svh"
module occ_clock_ctrl (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // configuration straps
  input wire logic [2:0] initial_source_cfg,
  input wire logic [1:0] primary_submode_cfg,
  input wire logic monitor_cfg_low,
  input wire logic failsafe_monitor_en,
  // source ticks
  input wire logic frc_tick,
  input wire logic prim_tick,
  input wire logic sec_tick,
  input wire logic slow_internal_rc_tick,
  input wire logic pll_tick,
  // asynchronous status from analog parts
  input wire logic pll_locked,
  input wire logic clock_fail,
  // interrupt event from the controller
  input wire logic irq_event,
  // pll and oscillator control
  output logic pll_enable,
  output logic pll_from_primary,
  output logic [5:0] pll_n1,
  output logic [9:0] pll_m,
  output logic [3:0] pll_n2,
  output logic low_power_osc_enable,
  output logic [5:0] rc_trim,
  output logic [1:0] primary_mode,
  output logic [2:0] active_source,
  // derived clock ticks
  output logic fosc_tick,
  output logic cy_tick,
  output logic cpu_tick
);

////////////////////////////////////////////////////////////////////////////////
// register state

  logic [2:0] act_src_r, act_src_nxt;
  logic [2:0] req_src_r, req_src_nxt;
  logic lock_en_r, lock_en_nxt;
  logic cf_r, cf_nxt;
  logic lpen_r, lpen_nxt;
  logic swreq_r, swreq_nxt;
  logic roi_r, roi_nxt;
  logic [2:0] doze_r, doze_nxt;
  logic ratio_reduce_enable_r, ratio_reduce_enable_nxt;
  logic [2:0] rc_postscale_sel_r, rc_postscale_sel_nxt;
  logic [1:0] post_r, post_nxt;
  logic [4:0] pre_r, pre_nxt;
  logic [8:0] fbd_r, fbd_nxt;
  logic [5:0] tun_r, tun_nxt;
  logic [1:0] submode_r;
  logic cfg_done_r;
  occ_pkg::occ_sw_e sw_st_r, sw_st_nxt;
  logic [3:0] settle_cnt_r, settle_cnt_nxt;

////////////////////////////////////////////////////////////////////////////////
// synchronisers for analog status

  logic lock_s1_r, lock_s2_r;
  logic fail_s1_r, fail_s2_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
      fail_s1_r <= 1'b0;
      fail_s2_r <= 1'b0;
    end else if (ce) begin
      lock_s1_r <= pll_locked;
      lock_s2_r <= lock_s1_r;
      fail_s1_r <= clock_fail;
      fail_s2_r <= fail_s1_r;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// ahb-lite address phase capture

  logic [11:0] dp_addr_r;
  logic dp_write_r;
  logic [31:0] hrdata_r;
  wire addr_phase = hsel & hready & htrans[1];
  wire ap_read = addr_phase & ~hwrite;
  wire ap_write = addr_phase & hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_addr_r <= 12'h000;
      dp_write_r <= 1'b0;
    end else if (ce) begin
      dp_addr_r <= haddr[11:0];
      dp_write_r <= ap_write;
    end
  end

  // whole-word writes only; the low half carries the 16-bit register
  wire wr_osc = dp_write_r & (dp_addr_r == `OCC_OFS_OSC);
  wire wr_div = dp_write_r & (dp_addr_r == `OCC_OFS_DIV);
  wire wr_fbd = dp_write_r & (dp_addr_r == `OCC_OFS_FBD);
  wire wr_tun = dp_write_r & (dp_addr_r == `OCC_OFS_TUN);

////////////////////////////////////////////////////////////////////////////////
// read mux

  logic pll_ok;
  wire [15:0] rd_osc = {1'b0, act_src_r, 1'b0, req_src_r,
                        lock_en_r, 1'b0, pll_ok, 1'b0,
                        cf_r, 1'b0, lpen_r, swreq_r};
  wire [15:0] rd_div = {roi_r, doze_r, ratio_reduce_enable_r, rc_postscale_sel_r,
                        post_r, 1'b0, pre_r};
  wire [15:0] rd_fbd = {7'h00, fbd_r};
  wire [15:0] rd_tun = {10'h000, tun_r};
  wire [11:0] ap_addr = haddr[11:0];
  wire [15:0] rd_word = (ap_addr == `OCC_OFS_OSC) ? rd_osc :
                        (ap_addr == `OCC_OFS_DIV) ? rd_div :
                        (ap_addr == `OCC_OFS_FBD) ? rd_fbd :
                        (ap_addr == `OCC_OFS_TUN) ? rd_tun : 16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ce && ap_read) begin
      hrdata_r <= {16'h0000, rd_word};
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

////////////////////////////////////////////////////////////////////////////////
// source decode helpers

  function automatic logic is_pll(input logic [2:0] code);
    is_pll = (code == occ_pkg::SRC_FRC_PLL) | (code == occ_pkg::SRC_PRI_PLL);
  endfunction : is_pll

  function automatic logic src_tick(input logic [2:0] code, input logic t_frc,
                                    input logic t_pri, input logic t_sec,
                                    input logic t_slow_internal_rc, input logic t_pll);
    unique case (code)
      occ_pkg::SRC_FRC_PLL, occ_pkg::SRC_PRI_PLL: src_tick = t_pll;
      occ_pkg::SRC_PRI: src_tick = t_pri;
      occ_pkg::SRC_SEC: src_tick = t_sec;
      occ_pkg::SRC_SLOW_INTERNAL_RC: src_tick = t_slow_internal_rc;
      default: src_tick = t_frc;
    endcase
  endfunction : src_tick

  wire cfg_locked = lock_en_r & monitor_cfg_low;
  wire switching = (sw_st_r != occ_pkg::SW_IDLE);
  wire pll_in_use = is_pll(act_src_r) | (switching & is_pll(req_src_r));
  assign pll_ok = pll_in_use & lock_s2_r;
  wire fail_event = failsafe_monitor_en & fail_s2_r;
  // settling counts raw ticks of the target; postscaling is not applied here
  wire new_tick = src_tick(req_src_r, frc_tick, prim_tick, sec_tick,
                           slow_internal_rc_tick, pll_tick);

////////////////////////////////////////////////////////////////////////////////
// oscillator control register and switch sequencer

  always_comb begin
    act_src_nxt = act_src_r;
    req_src_nxt = req_src_r;
    lock_en_nxt = lock_en_r;
    cf_nxt = cf_r;
    lpen_nxt = lpen_r;
    swreq_nxt = swreq_r;
    sw_st_nxt = sw_st_r;
    settle_cnt_nxt = settle_cnt_r;
    if (!cfg_done_r) begin
      act_src_nxt = initial_source_cfg;
      req_src_nxt = initial_source_cfg;
    end else begin
      if (wr_osc) begin
        lock_en_nxt = hwdata[`OCC_LOCKEN_BIT];
        lpen_nxt = hwdata[`OCC_LPEN_BIT];
        if (!cfg_locked) begin
          req_src_nxt = hwdata[`OCC_REQ_LSB +: 3];
          if (hwdata[`OCC_SWREQ_BIT]) begin
            swreq_nxt = 1'b1;
          end
        end
        if (!hwdata[`OCC_CF_BIT]) begin
          cf_nxt = 1'b0;
        end
      end
      unique case (sw_st_r)
        occ_pkg::SW_IDLE: begin
          if (swreq_r) begin
            if (req_src_r == act_src_r) begin
              swreq_nxt = 1'b0; // redundant switch, aborted
            end else begin
              cf_nxt = 1'b0;
              settle_cnt_nxt = 4'h0;
              sw_st_nxt = is_pll(req_src_r) ? occ_pkg::SW_LOCK : occ_pkg::SW_SETTLE;
            end
          end
        end
        occ_pkg::SW_LOCK: begin
          if (lock_s2_r) begin
            sw_st_nxt = occ_pkg::SW_SETTLE;
          end
        end
        occ_pkg::SW_SETTLE: begin
          if (new_tick) begin
            if (settle_cnt_r == `OCC_SWITCH_TICKS - 4'h1) begin
              act_src_nxt = req_src_r;
              swreq_nxt = 1'b0;
              sw_st_nxt = occ_pkg::SW_IDLE;
            end else begin
              settle_cnt_nxt = settle_cnt_r + 4'h1;
            end
          end
        end
      endcase
      // failure wins over any switch and over a clear in the same cycle
      if (fail_event) begin
        cf_nxt = 1'b1;
        act_src_nxt = is_pll(act_src_r) ? occ_pkg::SRC_FRC_PLL : occ_pkg::SRC_FRC;
        swreq_nxt = 1'b0;
        sw_st_nxt = occ_pkg::SW_IDLE;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_src_r <= `OCC_RST_SRC;
      req_src_r <= `OCC_RST_SRC;
      lock_en_r <= 1'b0;
      cf_r <= 1'b0;
      lpen_r <= 1'b0;
      swreq_r <= 1'b0;
      sw_st_r <= occ_pkg::SW_IDLE;
      settle_cnt_r <= 4'h0;
    end else if (ce) begin
      act_src_r <= act_src_nxt;
      req_src_r <= req_src_nxt;
      lock_en_r <= lock_en_nxt;
      cf_r <= cf_nxt;
      lpen_r <= lpen_nxt;
      swreq_r <= swreq_nxt;
      sw_st_r <= sw_st_nxt;
      settle_cnt_r <= settle_cnt_nxt;
    end
  end

  // source and submode straps are caught on the first enabled edge after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_done_r <= 1'b0;
      submode_r <= 2'h0;
    end else if (ce && !cfg_done_r) begin
      cfg_done_r <= 1'b1;
      submode_r <= primary_submode_cfg;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// divisor, feedback and tuning registers

  always_comb begin
    roi_nxt = roi_r;
    doze_nxt = doze_r;
    ratio_reduce_enable_nxt = ratio_reduce_enable_r;
    rc_postscale_sel_nxt = rc_postscale_sel_r;
    post_nxt = post_r;
    pre_nxt = pre_r;
    fbd_nxt = fbd_r;
    tun_nxt = tun_r;
    if (wr_div) begin
      roi_nxt = hwdata[`OCC_ROI_BIT];
      doze_nxt = hwdata[`OCC_DOZE_LSB +: 3];
      ratio_reduce_enable_nxt = hwdata[`OCC_RATIO_REDUCE_ENABLE_BIT];
      if (!cfg_locked) begin
        rc_postscale_sel_nxt = hwdata[`OCC_RC_POSTSCALE_SEL_LSB +: 3];
        post_nxt = hwdata[`OCC_POST_LSB +: 2];
        pre_nxt = hwdata[`OCC_PRE_LSB +: 5];
      end
    end
    if (wr_fbd && !cfg_locked) begin
      fbd_nxt = hwdata[8:0];
    end
    if (wr_tun) begin
      tun_nxt = hwdata[5:0];
    end
    if (roi_r && irq_event) begin
      ratio_reduce_enable_nxt = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      roi_r <= 1'b0;
      doze_r <= `OCC_RST_DOZE;
      ratio_reduce_enable_r <= 1'b0;
      rc_postscale_sel_r <= `OCC_RST_RC_POSTSCALE_SEL;
      post_r <= `OCC_RST_POST;
      pre_r <= `OCC_RST_PRE;
      fbd_r <= `OCC_RST_FBD;
      tun_r <= `OCC_RST_TUN;
    end else if (ce) begin
      roi_r <= roi_nxt;
      doze_r <= doze_nxt;
      ratio_reduce_enable_r <= ratio_reduce_enable_nxt;
      rc_postscale_sel_r <= rc_postscale_sel_nxt;
      post_r <= post_nxt;
      pre_r <= pre_nxt;
      fbd_r <= fbd_nxt;
      tun_r <= tun_nxt;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// pll factors; the analog loop forms fin * m / (n1 * n2)

  wire [5:0] n1_val = {1'b0, pre_r} + 6'd2;
  wire [9:0] m_val = {1'b0, fbd_r} + 10'd2;
  // reserved post code falls back to the reset divide so the loop stays in range
  wire [3:0] n2_val = (post_r == 2'b00) ? 4'd2 :
                      (post_r == 2'b11) ? 4'd8 : 4'd4;

  logic [5:0] pll_n1_r;
  logic [9:0] pll_m_r;
  logic [3:0] pll_n2_r;
  logic pll_en_r;
  logic pll_pri_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_n1_r <= 6'd2;
      pll_m_r <= 10'd50;
      pll_n2_r <= 4'd4;
      pll_en_r <= 1'b0;
      pll_pri_r <= 1'b0;
    end else if (ce) begin
      pll_n1_r <= n1_val;
      pll_m_r <= m_val;
      pll_n2_r <= n2_val;
      // the strap decides the first cycle so a pll strap never starts with the loop off
      pll_en_r <= cfg_done_r ? pll_in_use : is_pll(initial_source_cfg);
      pll_pri_r <= is_pll(req_src_r) & switching ? req_src_r[1] : act_src_r[1];
    end
  end

////////////////////////////////////////////////////////////////////////////////
// rc postscaler and oscillator tick select

  logic [7:0] frc_cnt_r;
  // divide-by-16 mode uses the same counter with a fixed code
  wire [2:0] frc_code = (act_src_r == occ_pkg::SRC_FRC_D16) ? `OCC_FRC16_CODE : rc_postscale_sel_r;
  wire [7:0] frc_term = (frc_code == 3'h7) ? 8'hFF :
                        8'(8'h01 << frc_code) - 8'h01;
  wire frc_div_hit = frc_tick & (frc_cnt_r >= frc_term);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frc_cnt_r <= 8'h00;
    end else if (ce && frc_tick) begin
      frc_cnt_r <= frc_div_hit ? 8'h00 : frc_cnt_r + 8'h01;
    end
  end

  wire is_divided = (act_src_r == occ_pkg::SRC_FRC_D16) |
                    (act_src_r == occ_pkg::SRC_FRC_DN);
  wire fosc_sel = is_divided ? frc_div_hit :
                  src_tick(act_src_r, frc_tick, prim_tick, sec_tick,
                           slow_internal_rc_tick, pll_tick);

////////////////////////////////////////////////////////////////////////////////
// instruction and processor ticks

  logic fosc_tick_r;
  logic cy_ph_r;
  logic cy_tick_r;
  logic [6:0] doze_cnt_r;
  logic cpu_tick_r;
  wire cy_hit = fosc_sel & cy_ph_r;
  wire [6:0] doze_term = 7'(8'(8'h01 << doze_r) - 8'h01);
  wire doze_hit = ~ratio_reduce_enable_r | (doze_cnt_r >= doze_term);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fosc_tick_r <= 1'b0;
      cy_ph_r <= 1'b0;
      cy_tick_r <= 1'b0;
      doze_cnt_r <= 7'h00;
      cpu_tick_r <= 1'b0;
    end else if (ce) begin
      fosc_tick_r <= fosc_sel;
      if (fosc_sel) begin
        cy_ph_r <= ~cy_ph_r;
      end
      cy_tick_r <= cy_hit;
      cpu_tick_r <= cy_hit & doze_hit;
      if (cy_hit) begin
        doze_cnt_r <= doze_hit ? 7'h00 : doze_cnt_r + 7'h01;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// outputs

  assign pll_enable = pll_en_r;
  assign pll_from_primary = pll_pri_r;
  assign pll_n1 = pll_n1_r;
  assign pll_m = pll_m_r;
  assign pll_n2 = pll_n2_r;
  assign low_power_osc_enable = lpen_r;
  assign rc_trim = tun_r;
  assign primary_mode = submode_r;
  assign active_source = act_src_r;
  assign fosc_tick = fosc_tick_r;
  assign cy_tick = cy_tick_r;
  assign cpu_tick = cpu_tick_r;

endmodule : occ_clock_ctrl

// *** hdl/occ_defs.svh ***
// Purpose: offsets, field positions, reset values and counts of the clock controller
// Assumes: included by its bare name
`ifndef OCC_DEFS_SVH
`define OCC_DEFS_SVH
`define OCC_OFS_OSC 12'h000
`define OCC_OFS_DIV 12'h004
`define OCC_OFS_FBD 12'h008
`define OCC_OFS_TUN 12'h00C
`define OCC_ACT_LSB 12
`define OCC_REQ_LSB 8
`define OCC_LOCKEN_BIT 7
`define OCC_PLLOK_BIT 5
`define OCC_CF_BIT 3
`define OCC_LPEN_BIT 1
`define OCC_SWREQ_BIT 0
`define OCC_ROI_BIT 15
`define OCC_DOZE_LSB 12
`define OCC_RATIO_REDUCE_ENABLE_BIT 11
`define OCC_RC_POSTSCALE_SEL_LSB 8
`define OCC_POST_LSB 6
`define OCC_PRE_LSB 0
`define OCC_RST_SRC 3'h7
`define OCC_RST_DOZE 3'h3
`define OCC_RST_RC_POSTSCALE_SEL 3'h0
`define OCC_RST_POST 2'h1
`define OCC_RST_PRE 5'h00
`define OCC_RST_FBD 9'h030
`define OCC_RST_TUN 6'h00
`define OCC_SWITCH_TICKS 4'hA
`define OCC_FRC16_CODE 3'h4
`endif

// *** hdl/occ_pkg.sv ***
// Purpose: types of the clock controller
// Assumes: nothing
// Notes: used by occ_clock_ctrl
package occ_pkg;
  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_LOCK = 3'b010,
    SW_SETTLE = 3'b100
  } occ_sw_e;
  typedef enum logic [2:0] {
    SRC_FRC = 3'b000,
    SRC_FRC_PLL = 3'b001,
    SRC_PRI = 3'b010,
    SRC_PRI_PLL = 3'b011,
    SRC_SEC = 3'b100,
    SRC_SLOW_INTERNAL_RC = 3'b101,
    SRC_FRC_D16 = 3'b110,
    SRC_FRC_DN = 3'b111
  } occ_src_e;
endpackage : occ_pkg
